// [rtl/qdr_axis.sv]
// One encoder axis: synchroniser, 4x decoder, CW and CCW counters, registration capture.
// Assumes pins are asynchronous to i_clk_sys and that the encoder edge rate stays below
// a quarter of the clock so no two decoded edges fall in one cycle.
`timescale 1ns/100ps
module qdr_axis
	import qdr_pkg::*;
#(
	parameter int unsigned CNT_W = QDR_CNT_W
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire qdr_enc_pins_t i_pins,
	input wire qdr_reg_setup_t i_setup,
	input wire logic i_ack,
	output logic o_cw_pulse,
	output logic o_ccw_pulse,
	output logic [CNT_W-1:0] o_cw_count,
	output logic [CNT_W-1:0] o_ccw_count,
	output logic [CNT_W-1:0] o_capture,
	output logic o_captured,
	output logic o_marker
);
	////////////////////////////////////////////////////////////////
	// Two-stage synchroniser; stage one feeds only stage two
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [3:0] prev_r;
	// Fill marks: reset levels are not pin levels, so no edge is judged until
	// sync2_r and prev_r both hold real samples, else a false count follows reset
	logic [2:0] live_r;
	logic dec_en;
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			prev_r <= 4'h0;
			live_r <= 3'h0;
		end else begin
			sync1_r <= i_pins;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
			live_r <= {live_r[1:0], 1'b1};
		end
	end
	assign dec_en = live_r[2];

	////////////////////////////////////////////////////////////////
	// Direction decode; bit order of sync2_r is a,b,marker,reg_in
	logic a_s, b_s, a_p, b_p, a_chg, b_chg;
	logic cw_nxt, ccw_nxt;
	assign a_s = sync2_r[3];
	assign b_s = sync2_r[2];
	assign a_p = prev_r[3];
	assign b_p = prev_r[2];
	assign a_chg = a_s ^ a_p;
	assign b_chg = b_s ^ b_p;
	always_comb begin
		cw_nxt = 1'b0;
		ccw_nxt = 1'b0;
		// Every edge of either phase counts once; both at once is an illegal jump, dropped
		if (dec_en && a_chg && !b_chg) begin
			// A moved to differ from B means A leads: counterclockwise (forward)
			ccw_nxt = (a_s != b_s);
			cw_nxt = (a_s == b_s);
		end else if (dec_en && b_chg && !a_chg) begin
			// B moved to differ from A means B leads: clockwise (reverse)
			cw_nxt = (a_s != b_s);
			ccw_nxt = (a_s == b_s);
		end
	end

	////////////////////////////////////////////////////////////////
	// Count lines, counters, registration capture
	logic cw_r, ccw_r;
	logic [CNT_W-1:0] cwc_r, cwc_nxt, ccwc_r, ccwc_nxt, cap_r, cap_nxt;
	logic flag_r, flag_nxt, src_lvl, src_prev, trig;
	assign src_lvl = (i_setup.src == QDR_SRC_INPUT) ? sync2_r[0] : sync2_r[1];
	assign src_prev = (i_setup.src == QDR_SRC_INPUT) ? prev_r[0] : prev_r[1];
	assign trig = dec_en && i_setup.enable && (src_lvl != src_prev)
		&& (src_lvl == !i_setup.falling);
	always_comb begin
		cwc_nxt = cwc_r + CNT_W'(cw_r);
		ccwc_nxt = ccwc_r + CNT_W'(ccw_r);
		cap_nxt = cap_r;
		flag_nxt = flag_r;
		if (i_ack) begin
			flag_nxt = 1'b0;
		end
		// A same-cycle acknowledge drops a new event while flagged; a held capture is never overwritten
		if (trig && !flag_r) begin
			cap_nxt = cwc_nxt - ccwc_nxt;
			flag_nxt = 1'b1;
		end
	end
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			cw_r <= 1'b0;
			ccw_r <= 1'b0;
			cwc_r <= '0;
			ccwc_r <= '0;
			cap_r <= '0;
			flag_r <= 1'b0;
		end else begin
			cw_r <= cw_nxt;
			ccw_r <= ccw_nxt;
			cwc_r <= cwc_nxt;
			ccwc_r <= ccwc_nxt;
			cap_r <= cap_nxt;
			flag_r <= flag_nxt;
		end
	end
	assign o_cw_pulse = cw_r;
	assign o_ccw_pulse = ccw_r;
	assign o_cw_count = cwc_r;
	assign o_ccw_count = ccwc_r;
	assign o_capture = cap_r;
	assign o_captured = flag_r;
	assign o_marker = sync2_r[1];

	////////////////////////////////////////////////////////////////
	// Checks
	AST_EXCLUSIVE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!(cw_r && ccw_r)) else $error("cw and ccw pulse together");
	AST_CW_INC: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		cw_r |=> cwc_r == $past(cwc_r) + 1'b1) else $error("cw counter missed a pulse");
	AST_CCW_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!ccw_r |=> $stable(ccwc_r)) else $error("ccw counter moved without pulse");
	AST_A_LEAD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(dec_en && a_chg && !b_chg && a_s != b_s) |=> ccw_r) else $error("A lead not ccw");
	AST_B_LEAD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(dec_en && b_chg && !a_chg && a_s != b_s) |=> cw_r) else $error("B lead not cw");
	AST_EDGE_CNT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(dec_en && (a_chg ^ b_chg)) |=> (cw_r || ccw_r)) else $error("edge not counted");
	AST_CAPTURE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(trig && !flag_r) |=> flag_r && cap_r == cwc_r - ccwc_r) else $error("capture wrong");
	AST_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		flag_r |=> $stable(cap_r)) else $error("capture overwritten while flagged");
	AST_SYNC: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		live_r[1] |-> sync2_r == $past(i_pins, 2)) else $error("sync depth wrong");
	COV_CW: cover property (@(posedge i_clk_sys) disable iff (i_rst) cw_r);
	COV_CCW: cover property (@(posedge i_clk_sys) disable iff (i_rst) ccw_r);
	COV_CAP: cover property (@(posedge i_clk_sys) disable iff (i_rst) trig && !flag_r);
	COV_BLOCK: cover property (@(posedge i_clk_sys) disable iff (i_rst) trig && flag_r);
endmodule

// [rtl/qdr_pkg.sv]
// Shared constants and carrier types for the quadrature decode and registration block.
// Assumes a single 50 MHz system clock and an active-high asynchronous reset.
package qdr_pkg;
	localparam int unsigned QDR_AXES = 4;
	localparam int unsigned QDR_CNT_W = 32;
	localparam int unsigned QDR_SYNC_STAGES = 2;
	localparam logic [31:0] QDR_CNT_RST = 32'h0000_0000;
	localparam logic [1:0] QDR_PH_RST = 2'h0;

	// Registration source selection
	typedef enum logic {
		QDR_SRC_MARKER = 1'b0,
		QDR_SRC_INPUT = 1'b1
	} qdr_src_t;

	// Registration setup, one per axis, driven by the surrounding logic
	typedef struct packed {
		logic enable;
		qdr_src_t src;
		logic falling;
	} qdr_reg_setup_t;

	// Raw encoder pins of one axis
	typedef struct packed {
		logic ph_a;
		logic ph_b;
		logic marker;
		logic reg_in;
	} qdr_enc_pins_t;

	// Per-axis counter snapshot
	typedef struct packed {
		logic [31:0] cw_count;
		logic [31:0] ccw_count;
	} qdr_counts_t;
endpackage

// [rtl/qdr_top.sv]
// Top of the quadrature decode and registration block: one axis instance per encoder axis.
// Assumes encoder pins arrive asynchronously and setup/ack come from logic on i_clk_sys.
`timescale 1ns/100ps
module qdr_top
	import qdr_pkg::*;
#(
	parameter int unsigned AXES = QDR_AXES,
	parameter int unsigned CNT_W = QDR_CNT_W
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire qdr_enc_pins_t [AXES-1:0] i_pins,
	input wire qdr_reg_setup_t [AXES-1:0] i_setup,
	input wire logic [AXES-1:0] i_ack,
	output logic [AXES-1:0] o_cw_pulse,
	output logic [AXES-1:0] o_ccw_pulse,
	output logic [AXES-1:0][CNT_W-1:0] o_cw_count,
	output logic [AXES-1:0][CNT_W-1:0] o_ccw_count,
	output logic [AXES-1:0][CNT_W-1:0] o_capture,
	output logic [AXES-1:0] o_captured,
	output logic [AXES-1:0] o_marker
);
	////////////////////////////////////////////////////////////////
	// One independent decoder and capture per axis; each axis subtracts its own two counters
	// for the capture, so no subtractor is shared here
	for (genvar g = 0; g < AXES; g++) begin : g_axis
		qdr_axis #(
			.CNT_W(CNT_W)
		) u_axis (
			.i_clk_sys(i_clk_sys),
			.i_rst(i_rst),
			.i_pins(i_pins[g]),
			.i_setup(i_setup[g]),
			.i_ack(i_ack[g]),
			.o_cw_pulse(o_cw_pulse[g]),
			.o_ccw_pulse(o_ccw_pulse[g]),
			.o_cw_count(o_cw_count[g]),
			.o_ccw_count(o_ccw_count[g]),
			.o_capture(o_capture[g]),
			.o_captured(o_captured[g]),
			.o_marker(o_marker[g])
		);
	end
endmodule

// [tb/qdr_enc_model.sv]
// Behavioural quadrature encoder of one axis with a once-per-turn marker.
// Assumes the bench pulses i_step for one cycle per edge, on the falling clock edge.
`timescale 1ns/100ps
module qdr_enc_model
	import qdr_pkg::*;
#(
	parameter int LINES = 2
) (
	input wire logic i_clk_sys,
	input wire logic i_step,
	input wire logic i_fwd,
	input wire logic i_reg_in,
	output qdr_enc_pins_t o_pins
);
	int pos = 1;
	logic [1:0] mark_r = 2'h0;
	////////////////////////////////////////////////////////////////////////////////
	// Disk position; marker lags two cycles so it never meets a phase edge
	always @(negedge i_clk_sys) begin
		if (i_step) begin
			pos <= i_fwd ? (pos + 1) % (4 * LINES) : (pos + 4 * LINES - 1) % (4 * LINES);
		end
		mark_r <= {mark_r[0], pos == 0};
	end
	// Gray order 00,10,11,01 going forward, so A leads B
	assign o_pins = '{pos[1] ^ pos[0], pos[1], mark_r[1], i_reg_in};
endmodule

// [tb/testbench.sv]
// Self-checking bench: four encoder models drive the four axes of the block.
// Assumes the marker of every model sits at disk position zero.
`timescale 1ns/100ps
module testbench;
	import qdr_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	wire qdr_enc_pins_t [3:0] pins;
	qdr_reg_setup_t [3:0] setup = '0;
	logic [3:0] ack = 4'h0, step = 4'h0, fwd = 4'h0, reg_in = 4'h0;
	logic [3:0] cwp, ccwp, capd, mk;
	logic [3:0][31:0] cwc, ccwc, cap, e_cw = '0, e_ccw = '0;
	logic [3:0][31:0] n_cwp = '0, n_ccwp = '0;
	int n_fail = 0, n_compared = 0, cyc = 0;
	////////////////////////////////////////////////////////////////////////////////
	// Encoders and the block under test
	for (genvar g = 0; g < 4; g++) begin : g_enc
		qdr_enc_model i_enc (.i_clk_sys(i_clk_sys), .i_step(step[g]), .i_fwd(fwd[g]),
			.i_reg_in(reg_in[g]), .o_pins(pins[g]));
	end
	qdr_top i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_pins(pins), .i_setup(setup),
		.i_ack(ack), .o_cw_pulse(cwp), .o_ccw_pulse(ccwp), .o_cw_count(cwc),
		.o_ccw_count(ccwc), .o_capture(cap), .o_captured(capd), .o_marker(mk));
	// Clock and a hang guard well above the expected run length
	initial forever #10 i_clk_sys = ~i_clk_sys;
	// Pulse tallies on the falling edge, where the registered count lines are settled
	always @(negedge i_clk_sys) begin
		for (int i = 0; i < 4; i++) begin
			if (cwp[i] === 1'b1) n_cwp[i] <= n_cwp[i] + 32'h1;
			if (ccwp[i] === 1'b1) n_ccwp[i] <= n_ccwp[i] + 32'h1;
		end
	end
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_fail++;
			complete_run();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One step per four cycles keeps each phase well over two cycles apart
	task automatic move(input logic [3:0] ax, input logic dir, input int n);
		repeat (n) begin
			@(negedge i_clk_sys) step <= ax;
			fwd <= {4{dir}};
			@(negedge i_clk_sys) step <= 4'h0;
			repeat (2) @(negedge i_clk_sys);
			for (int i = 0; i < 4; i++) begin
				if (ax[i] && dir) e_ccw[i]++;
				else if (ax[i]) e_cw[i]++;
			end
		end
		repeat (8) @(negedge i_clk_sys);
	endtask
	task automatic chk_counts();
		for (int i = 0; i < 4; i++) begin
			chk(cwc[i], e_cw[i]);
			chk(ccwc[i], e_ccw[i]);
			chk(n_cwp[i], e_cw[i]);
			chk(n_ccwp[i], e_ccw[i]);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Forward on all axes, then reverse on two, each edge counted once
	task automatic t_count();
		move(4'hf, 1'b1, 8);
		chk_counts();
		move(4'h5, 1'b0, 3);
		chk_counts();
		$display("test count done");
	endtask
	// Marker rising capture, held while flagged, released by ack
	task automatic t_marker();
		logic [31:0] exp;
		setup[0] <= '{1'b1, QDR_SRC_MARKER, 1'b0};
		move(4'h1, 1'b1, 2);
		exp = e_cw[0] - e_ccw[0];
		chk(mk[0], 1'b1);
		chk(capd[0], 1'b1);
		chk(cap[0], exp);
		move(4'h1, 1'b1, 8);
		chk(cap[0], exp);
		@(negedge i_clk_sys) ack[0] <= 1'b1;
		@(negedge i_clk_sys) ack[0] <= 1'b0;
		chk(capd[0], 1'b0);
		$display("test marker done");
	endtask
	// Input source on falling edge only, axis 2 left untouched
	task automatic t_input();
		setup[1] <= '{1'b1, QDR_SRC_INPUT, 1'b1};
		reg_in[1] <= 1'b1;
		repeat (8) @(negedge i_clk_sys);
		chk(capd[1], 1'b0);
		move(4'h2, 1'b0, 2);
		reg_in[1] <= 1'b0;
		repeat (8) @(negedge i_clk_sys);
		chk(capd[1], 1'b1);
		chk(cap[1], e_cw[1] - e_ccw[1]);
		chk(capd[2], 1'b0);
		$display("test input done");
	endtask
	task automatic complete_run();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Reset for eight cycles, then the scenarios
	initial begin
		repeat (8) @(negedge i_clk_sys);
		i_rst = 1'b0;
		t_count();
		t_marker();
		t_input();
		complete_run();
	end
endmodule
